// >>> rtl/sbs_sequencer.sv
// Module: power-fail sequencer gating SRAM chip enable, resets, warning and seal
//
// Behaviour
// [RULE_01] Normal supply: chip enable out follows input
// [RULE_02] Supply below trip: chip enable forced high
// [RULE_03] Access in flight held until end or limit
// [RULE_04] Idle chip enable disabled at once
// [RULE_05] Three below-ground pulses enter freshness seal
// [RULE_06] Seal pulses applied only during normal supply
// [RULE_07] Seal tristates supply, resets, chip enable
// [RULE_08] Seal drives watchdog flag low
// [RULE_09] Battery switch flag keeps working under seal
// [RULE_10] Seal leaves only after supply power cycle
// [RULE_11] Battery flag follows supply versus battery level
// [RULE_12] Warning interrupt fires first on sense drop
// [RULE_13] Trip: both resets and chip enable together
// [RULE_14] Power-up clears battery flag above battery
// [RULE_15] Power-up reset held full reset time
// [RULE_16] Each later sense drop gives new warning
// [RULE_17] Missing kick causes watchdog reset
// [RULE_18] Warning needs three consecutive 33us samples
// [RULE_19] Watchdog 20480 clocks first, then 5120
// [RULE_20] Access hold limit at most 5 us
// [RULE_21] Comparator results are synchronous digital inputs
// [RULE_22] Seal pulse count clears outside normal supply
`timescale 1ns/10ps
module sbs_sequencer #(
  parameter int unsigned PU_RESET_CYC = sbs_pkg::POWERUP_RESET_CYC, // Power-up reset hold, cycles
  parameter int unsigned WD_FIRST     = sbs_pkg::WD_FIRST_CLKS,     // First watchdog period, osc clocks
  parameter int unsigned WD_NORMAL    = sbs_pkg::WD_NORMAL_CLKS,    // Later watchdog periods, osc clocks
  parameter int unsigned WD_RST_LEN   = sbs_pkg::WD_RESET_CLKS,     // Watchdog reset length, osc clocks
  parameter int unsigned SAMPLE_CYC   = sbs_pkg::SAMPLE_PERIOD_CYC  // Sense sample interval, cycles
) (
  input  wire logic sys_clk,              // System clock, 50 MHz
  input  wire logic rst,                  // Synchronous reset, active high
  input  wire logic supply_below_trip,    // Supply under supply_trip_level
  input  wire logic supply_below_batt,    // Supply under battery level
  input  wire logic sense_below_warn,     // early_warn_sense under warn_trip_level
  input  wire logic sense_below_ground,   // early_warn_sense pulse below ground
  input  wire logic chip_enable_in_n,     // Processor chip enable, active low
  input  wire logic kick_in_n,            // Watchdog kick, falling edge counts
  input  wire logic kick_open,            // Kick pin left open: watchdog off
  input  wire logic osc_clk_in,           // External watchdog oscillator level
  output logic      chip_enable_out_n,    // SRAM chip enable, active low
  output logic      chip_enable_out_oe,   // Drive enable for chip enable
  output logic      reset_out,            // Reset, active high
  output logic      reset_out_oe,         // Drive enable for reset_out
  output logic      reset_out_n,          // Reset, active low
  output logic      reset_out_n_oe,       // Drive enable for reset_out_n
  output logic      switched_sram_supply, // SRAM supply switch on
  output logic      power_warn_irq_n,     // Early power-fail warning, active low
  output logic      power_warn_irq_oe,    // Drive enable for warning
  output logic      battery_switch_flag,  // Supply at or under battery level
  output logic      watchdog_flag_n,      // Latched watchdog status, active low
  output logic      seal_active           // Freshness seal engaged
);

  localparam int unsigned PCW = $clog2(PU_RESET_CYC + 1);
  localparam int unsigned HCW = $clog2(sbs_pkg::CYCLE_HOLD_CYC + 1);
  localparam int unsigned WCW = $clog2(WD_FIRST + 1);
  localparam int unsigned SCW = $clog2(sbs_pkg::SEAL_PULSES + 1);

  typedef struct packed {
    sbs_pkg::sbs_state_t state;
    logic [PCW-1:0]      pu_cnt;
    logic [HCW-1:0]      hold_cnt;
    logic [WCW-1:0]      wd_cnt;
    logic                wd_first;
    logic [SCW-1:0]      seal_cnt;
    logic                seal;
    logic                seal_saw_off;
    logic                ground_d;
    logic                kick_d;
    logic                osc_d;
    logic                ce_n;
    logic                rst_act;
    logic                warn_n;
    logic                warn_oe;
    logic                batt;
    logic                wds_n;
  } sbs_st_t;

  sbs_st_t st_r;
  sbs_st_t st_nxt;
  logic    warn_filt;

  // ------------------------------------------------------------------
  // Sense filter
  // ------------------------------------------------------------------
  // Comparator levels come in already synchronised  // see [RULE_21]
  sbs_tick_filter #(
    .PERIOD_CYC (SAMPLE_CYC),
    .SAMPLES    (sbs_pkg::WARN_SAMPLES)
  ) u_warn_filter (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .level_in (sense_below_warn),
    .filtered (warn_filt)                 // see [RULE_18]
  );

  // ------------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------------
  logic osc_rise;
  logic kick_fall;
  logic ground_rise;
  logic wd_on;
  logic wd_expired;

  always_comb begin
    st_nxt      = st_r;
    osc_rise    = osc_clk_in & ~st_r.osc_d;
    kick_fall   = ~kick_in_n & st_r.kick_d;
    ground_rise = sense_below_ground & ~st_r.ground_d;
    wd_on       = ~kick_open & ~supply_below_trip;
    wd_expired  = st_r.wd_cnt == (st_r.wd_first ? WCW'(WD_FIRST) : WCW'(WD_NORMAL));

    st_nxt.osc_d    = osc_clk_in;
    st_nxt.kick_d   = kick_in_n;
    st_nxt.ground_d = sense_below_ground;

    // Battery flag tracks supply against battery, also under seal  // see [RULE_11]
    st_nxt.batt = supply_below_batt;      // see [RULE_09] see [RULE_14]

    // Warning: blocked while supply is still rising to the trip level,
    // but once set it follows the supply down   // see [RULE_12] see [RULE_16]
    if (!warn_filt)
      st_nxt.warn_n = 1'b1;
    else if (!supply_below_trip || !st_r.warn_n)
      st_nxt.warn_n = 1'b0;
    st_nxt.warn_oe = ~supply_below_batt;

    unique case (st_r.state)
      sbs_pkg::SBS_POWERUP: begin
        st_nxt.ce_n    = 1'b1;
        st_nxt.rst_act = 1'b1;
        if (supply_below_trip) begin
          st_nxt.pu_cnt = '0;
        end else if (st_r.pu_cnt == PCW'(PU_RESET_CYC - 1)) begin
          // Reset released after the full hold since supply valid  // see [RULE_15]
          st_nxt.state    = sbs_pkg::SBS_RUN;
          st_nxt.rst_act  = 1'b0;
          st_nxt.ce_n     = chip_enable_in_n;
          st_nxt.wd_cnt   = '0;
          st_nxt.wd_first = 1'b1;
        end else begin
          st_nxt.pu_cnt = st_r.pu_cnt + PCW'(1);
        end
      end
      sbs_pkg::SBS_RUN: begin
        if (supply_below_trip) begin
          st_nxt.rst_act  = 1'b1;          // see [RULE_13]
          st_nxt.hold_cnt = '0;
          if (!chip_enable_in_n && !st_r.ce_n) begin
            st_nxt.state = sbs_pkg::SBS_HOLD;   // see [RULE_03]
          end else begin
            st_nxt.state = sbs_pkg::SBS_DOWN;
            st_nxt.ce_n  = 1'b1;           // see [RULE_02] see [RULE_04] see [RULE_13]
          end
        end else begin
          st_nxt.ce_n = chip_enable_in_n;  // see [RULE_01]
          if (!wd_on || kick_fall) begin
            st_nxt.wd_cnt = '0;
            if (kick_fall) begin
              st_nxt.wds_n    = 1'b1;
              st_nxt.wd_first = 1'b0;
            end
          end else if (wd_expired) begin
            // Missing kick: latched flag plus a timed reset  // see [RULE_17] see [RULE_19]
            st_nxt.wds_n   = 1'b0;
            st_nxt.rst_act = 1'b1;
            st_nxt.wd_cnt  = '0;
            st_nxt.state   = sbs_pkg::SBS_WDRST;
          end else if (osc_rise) begin
            st_nxt.wd_cnt = st_r.wd_cnt + WCW'(1);
          end
        end
      end
      sbs_pkg::SBS_HOLD: begin
        // Access keeps its level until it ends or the limit runs out  // see [RULE_03] see [RULE_20]
        if (chip_enable_in_n || st_r.hold_cnt == HCW'(sbs_pkg::CYCLE_HOLD_CYC - 1)) begin
          st_nxt.ce_n  = 1'b1;
          st_nxt.state = sbs_pkg::SBS_DOWN;
        end else begin
          st_nxt.hold_cnt = st_r.hold_cnt + HCW'(1);
        end
      end
      sbs_pkg::SBS_DOWN: begin
        st_nxt.ce_n    = 1'b1;
        st_nxt.rst_act = 1'b1;
        if (!supply_below_trip) begin
          st_nxt.state  = sbs_pkg::SBS_POWERUP;
          st_nxt.pu_cnt = '0;
        end
      end
      sbs_pkg::SBS_WDRST: begin
        st_nxt.ce_n = chip_enable_in_n;
        if (supply_below_trip) begin
          st_nxt.state = sbs_pkg::SBS_DOWN;
          st_nxt.ce_n  = 1'b1;              // see [RULE_13]
        end else if (st_r.wd_cnt == WCW'(WD_RST_LEN)) begin
          st_nxt.rst_act  = 1'b0;
          st_nxt.wd_cnt   = '0;
          st_nxt.wd_first = 1'b1;
          st_nxt.state    = sbs_pkg::SBS_RUN;
        end else if (osc_rise) begin
          st_nxt.wd_cnt = st_r.wd_cnt + WCW'(1);
        end
      end
      default: begin
        st_nxt.state = sbs_pkg::SBS_POWERUP;
      end
    endcase

    // Watchdog status shows low whenever supply is under trip
    if (supply_below_trip)
      st_nxt.wds_n = 1'b0;
    else if (st_r.state == sbs_pkg::SBS_DOWN)
      st_nxt.wds_n = 1'b1;

    // ----------------------------------------------------------------
    // Freshness seal
    // ----------------------------------------------------------------
    // Pulses only count while supply is normal; a sagging supply could
    // otherwise arm the seal from a noisy sense pin   // see [RULE_06] see [RULE_22]
    if (supply_below_trip)
      st_nxt.seal_cnt = '0;
    else if (ground_rise && !st_r.seal) begin
      if (st_r.seal_cnt == SCW'(sbs_pkg::SEAL_PULSES - 1)) begin
        st_nxt.seal         = 1'b1;        // see [RULE_05]
        st_nxt.seal_saw_off = 1'b0;
        st_nxt.seal_cnt     = '0;
      end else begin
        st_nxt.seal_cnt = st_r.seal_cnt + SCW'(1);
      end
    end

    // Exit needs supply gone below battery, then back above it  // see [RULE_10]
    if (st_r.seal) begin
      if (supply_below_batt)
        st_nxt.seal_saw_off = 1'b1;
      else if (st_r.seal_saw_off)
        st_nxt.seal = 1'b0;
    end
    // Flag low from the first sealed cycle on, not one cycle late
    if (st_nxt.seal)
      st_nxt.wds_n = 1'b0;                  // see [RULE_08]
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r              <= '0;
      st_r.state        <= sbs_pkg::SBS_POWERUP;
      st_r.ce_n         <= 1'b1;
      st_r.rst_act      <= 1'b1;
      st_r.warn_n       <= 1'b1;
      st_r.wds_n        <= 1'b1;
      st_r.kick_d       <= 1'b1;
      st_r.wd_first     <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all straight from the state flops
  // ------------------------------------------------------------------
  // Seal releases chip enable, both resets and SRAM supply; warning and battery flag keep driving  // see [RULE_07]
  assign chip_enable_out_n    = st_r.ce_n;
  assign chip_enable_out_oe   = ~st_r.seal;
  assign reset_out            = st_r.rst_act;
  assign reset_out_n          = ~st_r.rst_act;
  assign reset_out_oe         = ~st_r.seal;
  assign reset_out_n_oe       = ~st_r.seal;
  assign switched_sram_supply = ~st_r.seal;
  assign power_warn_irq_n     = st_r.warn_n;
  assign power_warn_irq_oe    = st_r.warn_oe;
  assign battery_switch_flag  = st_r.batt;
  assign watchdog_flag_n      = st_r.wds_n;
  assign seal_active          = st_r.seal;

endmodule : sbs_sequencer

// >>> rtl/sbs_pkg.sv
// Package: timing constants and state encodings for the SRAM backup supervisor sequencer
package sbs_pkg;

  // ------------------------------------------------------------------
  // Clock
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;

  // ------------------------------------------------------------------
  // Times in their own units, then cycles derived from them
  // ------------------------------------------------------------------
  // Sense comparator sample interval (internal oscillator, ~33 us)
  localparam int unsigned SAMPLE_PERIOD_US   = 33;
  localparam int unsigned SAMPLE_PERIOD_CYC  = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;
  // Consecutive out-of-tolerance samples before the warning fires
  localparam int unsigned WARN_SAMPLES       = 3;
  // Longest hold of an access in flight after supply failure (rounded down)
  localparam int unsigned CYCLE_HOLD_US      = 5;
  localparam int unsigned CYCLE_HOLD_CYC     = (CYCLE_HOLD_US * 1000) / CLK_PERIOD_NS;
  // Power-up reset hold, typical figure
  localparam int unsigned POWERUP_RESET_MS   = 100;
  localparam int unsigned POWERUP_RESET_CYC  = (POWERUP_RESET_MS * 1000000) / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // Watchdog figures, counted in external oscillator clocks
  // ------------------------------------------------------------------
  localparam int unsigned WD_FIRST_CLKS      = 20480;
  localparam int unsigned WD_NORMAL_CLKS     = 5120;
  localparam int unsigned WD_RESET_CLKS      = 641;

  // ------------------------------------------------------------------
  // Freshness seal
  // ------------------------------------------------------------------
  localparam int unsigned SEAL_PULSES        = 3;

  // ------------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    SBS_POWERUP,
    SBS_RUN,
    SBS_HOLD,
    SBS_DOWN,
    SBS_WDRST
  } sbs_state_t;

endpackage : sbs_pkg

// >>> rtl/sbs_tick_filter.sv
// Module: consecutive-sample noise filter on a periodic sampling tick
`timescale 1ns/10ps
module sbs_tick_filter #(
  parameter int unsigned PERIOD_CYC = 1650,   // Cycles between samples
  parameter int unsigned SAMPLES    = 3       // Consecutive highs needed
) (
  input  wire logic sys_clk,                  // System clock
  input  wire logic rst,                      // Synchronous reset, active high
  input  wire logic level_in,                 // Raw comparator level
  output logic      filtered                  // High after SAMPLES high samples
);

  localparam int unsigned PW = $clog2(PERIOD_CYC + 1);
  localparam int unsigned SW = $clog2(SAMPLES + 1);

  typedef struct packed {
    logic [PW-1:0] tick_cnt;
    logic [SW-1:0] run_cnt;
    logic          out;
  } sbs_flt_t;

  sbs_flt_t st_r;
  sbs_flt_t st_nxt;

  // ------------------------------------------------------------------
  // Sampling and run counting
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (st_r.tick_cnt == PW'(PERIOD_CYC - 1)) begin
      st_nxt.tick_cnt = '0;
      if (level_in) begin
        if (st_r.run_cnt != SW'(SAMPLES))
          st_nxt.run_cnt = st_r.run_cnt + SW'(1);
      end else begin
        // One good sample clears the run count: noise cannot accumulate
        st_nxt.run_cnt = '0;
      end
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + PW'(1);
    end
    st_nxt.out = (st_nxt.run_cnt == SW'(SAMPLES));
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign filtered = st_r.out;

endmodule : sbs_tick_filter

// >>> dv/sbs_sequencer_monitor.sv
// Checker of the sequencer's port behaviour
`timescale 1ns/10ps
module sbs_monitor (
  input wire logic sys_clk,              // Clock
  input wire logic rst,                  // Reset
  input wire logic supply_below_trip,    // Supply under trip
  input wire logic supply_below_batt,    // Supply under battery
  input wire logic sense_below_warn,     // Sense under warn level
  input wire logic sense_below_ground,   // Below-ground pulse
  input wire logic chip_enable_in_n,     // Processor chip enable
  input wire logic chip_enable_out_n,    // SRAM chip enable
  input wire logic chip_enable_out_oe,   // Chip enable drive
  input wire logic reset_out,            // Reset high
  input wire logic reset_out_oe,         // Reset high drive
  input wire logic reset_out_n,          // Reset low
  input wire logic reset_out_n_oe,       // Reset low drive
  input wire logic switched_sram_supply, // SRAM supply on
  input wire logic power_warn_irq_n,     // Warning
  input wire logic battery_switch_flag,  // Battery flag
  input wire logic watchdog_flag_n,      // Watchdog flag
  input wire logic seal_active           // Seal engaged
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_CE_FOLLOW: assert property (
    !reset_out && !supply_below_trip |=> reset_out || seal_active || chip_enable_out_n == $past(chip_enable_in_n))
    else $error("chip enable out does not follow input");
  AST_TRIP_RESET: assert property (
    !reset_out && !seal_active && supply_below_trip |=> reset_out && !reset_out_n && !watchdog_flag_n)
    else $error("trip did not raise both resets");
  AST_CE_OFF: assert property (
    !reset_out && supply_below_trip && (chip_enable_out_n || chip_enable_in_n) |=> chip_enable_out_n)
    else $error("idle chip enable not disabled");
  AST_CE_HOLD: assert property (
    !reset_out && supply_below_trip && !chip_enable_out_n && !chip_enable_in_n
    |=> !chip_enable_out_n ##[1:251] chip_enable_out_n)
    else $error("access hold wrong");
  AST_BATT_FLAG: assert property (
    1'b1 |=> battery_switch_flag == $past(supply_below_batt))
    else $error("battery flag wrong");
  AST_SEAL_OUT: assert property (
    seal_active |-> !chip_enable_out_oe && !reset_out_oe && !reset_out_n_oe && !switched_sram_supply && !watchdog_flag_n)
    else $error("seal outputs wrong");
  AST_SEAL_ENTRY: assert property (
    $rose(seal_active) |-> $past(sense_below_ground) && !$past(supply_below_trip))
    else $error("seal entered without pulse");
  AST_WARN_FILTER: assert property (
    $fell(power_warn_irq_n) |-> $past(sense_below_warn, 8) && $past(sense_below_warn))
    else $error("warning without three samples");
endmodule : sbs_monitor

// >>> dv/sbs_host_model.sv
// Host processor model: chip enable, watchdog kicks, oscillator
`timescale 1ns/10ps
module sbs_host_model (
  input  wire logic sys_clk,         // Clock
  input  wire logic rst,             // Reset
  input  wire logic kick_en,         // Keep kicking
  input  wire logic access_req,      // Hold an access
  output logic      osc_clk_in,      // Oscillator, rise every 4 cycles
  output logic      kick_in_n,       // Kick pulse
  output logic      chip_enable_in_n // Chip enable
);
  logic [3:0] osc_cnt_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      osc_cnt_r        <= 4'h0;
      osc_clk_in       <= 1'b0;
      kick_in_n        <= 1'b1;
      chip_enable_in_n <= 1'b1;
    end else begin
      osc_cnt_r        <= osc_cnt_r + 4'h1;
      osc_clk_in       <= osc_cnt_r[1];
      // Kick every 4 oscillator clocks, well inside the short period
      kick_in_n        <= !(kick_en && osc_cnt_r == 4'hf);
      chip_enable_in_n <= !access_req;
    end
  end
endmodule : sbs_host_model

// >>> dv/tb_sbs_sequencer.sv
// Testbench of the sequencer with host model and checker
`timescale 1ns/10ps
module tb_sbs_sequencer;
  localparam int PU = 20;
  logic sys_clk, rst, supply_below_trip, supply_below_batt, sense_below_warn, sense_below_ground;
  logic kick_en, access_req, osc_clk_in, kick_in_n, chip_enable_in_n, chip_enable_out_n, chip_enable_out_oe;
  logic reset_out, reset_out_oe, reset_out_n, reset_out_n_oe, switched_sram_supply, power_warn_irq_n;
  logic power_warn_irq_oe, battery_switch_flag, watchdog_flag_n, seal_active;
  int   fail_count = 0;
  int   comparisons = 0;
  int   cycles = 0;
  int   n;
  sbs_sequencer #(.PU_RESET_CYC(PU), .WD_FIRST(40), .WD_NORMAL(10), .WD_RST_LEN(5), .SAMPLE_CYC(4)) u_dut (
    .sys_clk, .rst, .supply_below_trip, .supply_below_batt, .sense_below_warn, .sense_below_ground,
    .chip_enable_in_n, .kick_in_n, .kick_open(1'b0), .osc_clk_in, .chip_enable_out_n, .chip_enable_out_oe,
    .reset_out, .reset_out_oe, .reset_out_n, .reset_out_n_oe, .switched_sram_supply, .power_warn_irq_n,
    .power_warn_irq_oe, .battery_switch_flag, .watchdog_flag_n, .seal_active);
  sbs_host_model u_host (.sys_clk, .rst, .kick_en, .access_req, .osc_clk_in, .kick_in_n, .chip_enable_in_n);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %b expected %b", $time, got, exp);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : cyc
  task automatic wait_lvl(ref logic sig, input logic val, input int lim, output int k);
    k = 0;
    while (sig !== val && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
  endtask : wait_lvl
  task automatic pulses(input int k);
    repeat (k) begin
      sense_below_ground = 1'b1;
      cyc(1);
      sense_below_ground = 1'b0;
      cyc(2);
    end
  endtask : pulses
  // Supply recovery, then wait out the full power-up reset
  task automatic recover;
    supply_below_trip = 1'b0;
    wait_lvl(reset_out, 1'b0, PU + 10, n);
    check(n <= PU + 2, 1'b1);
  endtask : recover
  task automatic finish_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup;
    wait_lvl(reset_out, 1'b0, 100, n);
    check(n >= PU && n <= PU + 2, 1'b1);
    check(battery_switch_flag, 1'b0);
  endtask : t_powerup
  task automatic t_follow;
    logic p;
    p = chip_enable_in_n;
    for (int i = 0; i < 8; i++) begin
      access_req = i[0] ^ i[1];
      cyc(1);
      check(chip_enable_out_n, p);
      p = chip_enable_in_n;
    end
  endtask : t_follow
  task automatic t_warn;
    repeat (2) begin
      sense_below_warn = 1'b1;
      wait_lvl(power_warn_irq_n, 1'b0, 40, n);
      check(n >= 8 && n <= 15, 1'b1);
      check(reset_out, 1'b0);
      sense_below_warn = 1'b0;
      wait_lvl(power_warn_irq_n, 1'b1, 20, n);
      check(n <= 15, 1'b1);
    end
  endtask : t_warn
  task automatic t_wdog;
    kick_en = 1'b0;
    wait_lvl(reset_out, 1'b1, 100, n);
    check(n >= 20 && n <= 46, 1'b1);
    check(watchdog_flag_n, 1'b0);
    wait_lvl(reset_out, 1'b0, 60, n);
    wait_lvl(reset_out, 1'b1, 220, n);
    check(n >= 155 && n <= 166, 1'b1);
    kick_en = 1'b1;
    wait_lvl(reset_out, 1'b0, 60, n);
    cyc(20);
    check(watchdog_flag_n, 1'b1);
  endtask : t_wdog
  task automatic t_trip;
    access_req = 1'b1;
    cyc(3);
    supply_below_trip = 1'b1;
    cyc(1);
    check(reset_out, 1'b1);
    check(reset_out_n, 1'b0);
    check(chip_enable_out_n, 1'b0);
    cyc(20);
    check(chip_enable_out_n, 1'b0);
    access_req = 1'b0;
    wait_lvl(chip_enable_out_n, 1'b1, 5, n);
    check(n <= 3, 1'b1);
    supply_below_batt = 1'b1;
    cyc(2);
    check(battery_switch_flag, 1'b1);
    supply_below_batt = 1'b0;
    cyc(2);
    check(battery_switch_flag, 1'b0);
    recover();
    access_req = 1'b1;
    cyc(3);
    supply_below_trip = 1'b1;
    wait_lvl(chip_enable_out_n, 1'b1, 300, n);
    check(n >= 249 && n <= 252, 1'b1);
    recover();
    access_req = 1'b0;
    cyc(2);
    supply_below_trip = 1'b1;
    cyc(1);
    check(chip_enable_out_n, 1'b1);
    recover();
  endtask : t_trip
  task automatic t_seal;
    pulses(2);
    supply_below_trip = 1'b1;
    cyc(2);
    recover();
    pulses(2);
    check(seal_active, 1'b0);
    pulses(1);
    check(seal_active, 1'b1);
    check(chip_enable_out_oe | reset_out_oe | reset_out_n_oe | switched_sram_supply, 1'b0);
    check(watchdog_flag_n, 1'b0);
    supply_below_trip = 1'b1;
    supply_below_batt = 1'b1;
    cyc(2);
    check(battery_switch_flag, 1'b1);
    check(seal_active, 1'b1);
    supply_below_batt = 1'b0;
    cyc(2);
    check(seal_active, 1'b0);
    recover();
  endtask : t_seal
  // ----------------------------------------------------------------
  // Clock, sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    rst = 1'b1;
    supply_below_trip = 1'b0;
    supply_below_batt = 1'b0;
    sense_below_warn = 1'b0;
    sense_below_ground = 1'b0;
    kick_en = 1'b1;
    access_req = 1'b0;
    cyc(10);
    rst = 1'b0;
    t_powerup();
    t_follow();
    t_warn();
    t_wdog();
    t_trip();
    t_seal();
    finish_test();
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      finish_test();
    end
  end
endmodule : tb_sbs_sequencer
bind sbs_sequencer sbs_monitor u_mon (.sys_clk, .rst, .supply_below_trip, .supply_below_batt, .sense_below_warn,
  .sense_below_ground, .chip_enable_in_n, .chip_enable_out_n, .chip_enable_out_oe, .reset_out, .reset_out_oe,
  .reset_out_n, .reset_out_n_oe, .switched_sram_supply, .power_warn_irq_n, .battery_switch_flag,
  .watchdog_flag_n, .seal_active);
